// ==== lpwd_pkg.sv ====
/*
 * Constants for the slow-clock wakeup timer, watchdog, reset-cause and
 * power-mode block. Assumes an 8-bit special function register bus.
 */
`default_nettype none
package lpwd_pkg;

    typedef logic [7:0] byte_t;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam byte_t ADDR_POWER_MODE   = 8'h87;
    localparam byte_t ADDR_DATA_HIGH    = 8'hAB;
    localparam byte_t ADDR_DATA_LOW     = 8'hAC;
    localparam byte_t ADDR_SLOW_CMD     = 8'hAD;
    localparam byte_t ADDR_RESET_CAUSE  = 8'hB1;
    localparam byte_t ADDR_TICK_DIV     = 8'hB5;
    localparam byte_t ADDR_CLK_SHUTDOWN = 8'hB6;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int    IDLE_BIT      = 0;
    localparam int    STOP_BIT      = 1;
    localparam int    PDOWN_BIT     = 1;
    localparam int    BUSY_BIT      = 4;
    localparam int    CAUSE_BIT     = 0;
    localparam byte_t TICK_DIV_RST  = 8'h09;
    localparam byte_t MODE_RST      = 8'h00;
    localparam logic  CAUSE_POR     = 1'b0;
    localparam logic  CAUSE_WDOG    = 1'b1;

    // Startup lengths in low-power oscillator periods.
    localparam logic [3:0] STARTUP_POR  = 4'hE;
    localparam logic [3:0] STARTUP_WDOG = 4'hC;

    // ------------------------------------------------------------
    // Slow-domain opcodes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_WAKE_LOAD = 4'b0001,
        OP_READ_LATCH = 4'b0010,
        OP_READ_COUNT = 4'b0011,
        OP_WAKE_OFF  = 4'b0100,
        OP_WDOG_LOAD = 4'b1000
    } slow_op_t;

endpackage
`default_nettype wire

// ==== lowpower_wakeup_watchdog.sv ====
/*
 * Slow-clock tick divider, reloading wakeup timer, watchdog, reset-cause
 * register and idle/stop/power-down sequencing behind the SFR bus.
 * Assumes the CPU core drives the SFR strobes on clk_sys and that the
 * low-power oscillator and wake pins arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: a tick is issued every tick_period_divider+1 oscillator periods.
// R2: capture trigger output toggles each oscillator period, giving half frequency.
// R3: wakeup counter counts ticks down, interrupts at zero and reloads from latch.
// R4: wakeup counting is off after reset until the latch is first written.
// R5: each latch write reloads the wakeup counter with the new value.
// R6: opcodes disable wakeup or copy latch or counter into data registers.
// R7: first wakeup after N+1 to N+2 ticks, then every N+1 ticks.
// R8: a wakeup event sets the wakeup interrupt flag.
// R9: a wakeup event restarts a stopped oscillator regardless of its enable.
// R10: opcode 0x08 activates the watchdog, which stays on until reset.
// R11: watchdog loads the 16-bit data registers on the load opcode.
// R12: watchdog reaching zero resets the whole controller; the capture trigger and read data register are cleared only by power-on reset.
// R13: software waits for not busy, then writes high, low, command.
// R14: busy shows in command bit 4; software waits before clock shutdown access.
// R15: power-on reset reinitialises and holds the CPU 14 oscillator periods.
// R16: watchdog reset reinitialises and holds the CPU 12 oscillator periods.
// R17: reset cause register records last reset source and selects start address.
// R18: idle bit suspends the CPU while its clock keeps running.
// R19: any enabled interrupt clears idle; watchdog reset also ends it.
// R20: stop bit suspends the CPU; only watchdog reset ends it.
// R21: power-down bit stops clock and regulators, keeping state.
// R22: power-down ends on enabled pin low, wakeup event or watchdog reset.
// R23: software requests power-down by writing 0x2 or 0x3.
// R24: watchdog decrements once per tick; busy holds until slow side takes command.
module lowpower_wakeup_watchdog
    import lpwd_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          low_power_oscillator,
    input  wire lpwd_pkg::byte_t sfr_addr,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    input  wire lpwd_pkg::byte_t sfr_wdata,
    output lpwd_pkg::byte_t    sfr_rdata,
    input  wire logic          irq_pending,
    input  wire logic          wake_flag_clr,
    input  wire logic          ext_irq_zero_n,
    input  wire logic          ext_irq_one_n,
    input  wire logic [1:0]    port0_alternate_select,
    output logic               capture_trigger_input,
    output logic               wakeup_timer_irq,
    output logic               wake_irq_flag,
    output logic               clock_regulator_run,
    output logic               cpu_suspend,
    output logic               cpu_reset,
    output logic               boot_loader_sel
);
    import lpwd_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic       lp_s1_r;
    logic       lp_s2_r;
    logic       lp_s3_r;
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic       lp_edge;
    logic       pin_wake;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lp_s1_r <= 1'b0;
            lp_s2_r <= 1'b0;
            lp_s3_r <= 1'b0;
        end
        else
        begin
            lp_s1_r <= low_power_oscillator;
            lp_s2_r <= lp_s1_r;
            lp_s3_r <= lp_s2_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_s1_r <= 2'b11;
            pin_s2_r <= 2'b11;
        end
        else
        begin
            pin_s1_r <= {ext_irq_one_n, ext_irq_zero_n};
            pin_s2_r <= pin_s1_r;
        end
    end

    // The oscillator rising edge is the slow domain's enable pulse.
    assign lp_edge  = lp_s2_r & ~lp_s3_r;
    assign pin_wake = |(~pin_s2_r & port0_alternate_select); // R22

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    byte_t       div_r;
    byte_t       tick_cnt_r;
    byte_t       data_hi_r;
    byte_t       data_lo_r;
    byte_t       power_mode_control_r;
    byte_t       ck_r;
    logic [3:0]  cmd_r;
    logic        busy_r;
    logic        cause_r;
    logic [15:0] latch_r;
    logic [15:0] wake_cnt_r;
    logic        wake_en_r;
    logic        wake_skip_r;
    logic        wake_pulse_r;
    logic        wake_flag_r;
    logic [15:0] wd_cnt_r;
    logic        wd_act_r;
    logic [3:0]  boot_cnt_r;
    logic        cap_trig_r;
    byte_t       rdata_r;

    logic        tick;
    logic        exec;
    logic        exec_wake;
    logic        exec_wd;
    logic        wake_ev;
    logic        wd_fire;
    logic        sys_init;
    logic        cmd_go;
    logic [15:0] data_word;

    assign data_word = {data_hi_r, data_lo_r};
    // Compare with >= so that lowering the divider below the running count
    // takes effect at once instead of waiting for the counter to wrap.
    assign tick      = lp_edge && (tick_cnt_r >= div_r);
    assign exec      = busy_r && lp_edge;
    assign exec_wake = exec && (cmd_r == OP_WAKE_LOAD);
    assign exec_wd   = exec && (cmd_r == OP_WDOG_LOAD);
    assign cmd_go    = sfr_wr && (sfr_addr == ADDR_SLOW_CMD) && !busy_r;
    assign sys_init  = rst || wd_fire;

    // ------------------------------------------------------------
    // Tick divider and capture trigger
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
            tick_cnt_r <= 8'h00;
        else if (lp_edge)
            tick_cnt_r <= tick ? 8'h00 : 8'(tick_cnt_r + 8'h01); // R1
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cap_trig_r <= 1'b0;
        else if (lp_edge)
            cap_trig_r <= ~cap_trig_r; // R2
    end

    // ------------------------------------------------------------
    // Command handshake
    // ------------------------------------------------------------
    // A command written while busy is dropped, so software must poll.
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
        begin
            busy_r <= 1'b0;
            cmd_r  <= 4'h0;
        end
        else if (cmd_go)
        begin
            busy_r <= 1'b1; // R24
            cmd_r  <= sfr_wdata[3:0];
        end
        else if (exec)
            busy_r <= 1'b0; // R14
    end

    // Slow-domain readback wins over a CPU write made while busy.
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
        begin
            data_hi_r <= 8'h00;
            data_lo_r <= 8'h00;
        end
        else if (exec && cmd_r == OP_READ_LATCH)
            {data_hi_r, data_lo_r} <= latch_r; // R6
        else if (exec && cmd_r == OP_READ_COUNT)
            {data_hi_r, data_lo_r} <= wake_cnt_r; // R6
        else if (sfr_wr && sfr_addr == ADDR_DATA_HIGH)
            data_hi_r <= sfr_wdata; // R13
        else if (sfr_wr && sfr_addr == ADDR_DATA_LOW)
            data_lo_r <= sfr_wdata;
    end

    // ------------------------------------------------------------
    // Wakeup timer
    // ------------------------------------------------------------
    // The skipped first tick makes the first period N+1 to N+2 ticks.
    // A disable on the same oscillator edge wins, since it skips the reload.
    assign wake_ev = tick && wake_en_r && !wake_skip_r
                     && (wake_cnt_r == 16'h0000) && !exec_wake
                     && !(exec && cmd_r == OP_WAKE_OFF); // R3

    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
        begin
            latch_r     <= 16'h0000;
            wake_cnt_r  <= 16'h0000;
            wake_en_r   <= 1'b0; // R4
            wake_skip_r <= 1'b0;
        end
        else if (exec_wake)
        begin
            latch_r     <= data_word;
            wake_cnt_r  <= data_word; // R5
            wake_en_r   <= 1'b1; // R4
            wake_skip_r <= 1'b1; // R7
        end
        else if (exec && cmd_r == OP_WAKE_OFF)
            wake_en_r <= 1'b0; // R6
        else if (tick && wake_en_r)
        begin
            if (wake_skip_r)
                wake_skip_r <= 1'b0;
            else if (wake_cnt_r == 16'h0000)
                wake_cnt_r <= latch_r; // R3
            else
                wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
    end

    // The flag's set beats a same-cycle clear so no wakeup is lost.
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
        begin
            wake_pulse_r <= 1'b0;
            wake_flag_r  <= 1'b0;
        end
        else
        begin
            wake_pulse_r <= wake_ev;
            if (wake_ev)
                wake_flag_r <= 1'b1; // R8
            else if (wake_flag_clr)
                wake_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // A load on the same oscillator edge as expiry rescues the system.
    assign wd_fire = tick && wd_act_r && (wd_cnt_r <= 16'h0001)
                     && !exec_wd; // R12

    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
        begin
            wd_act_r <= 1'b0;
            wd_cnt_r <= 16'h0000;
        end
        else if (exec_wd)
        begin
            wd_act_r <= 1'b1; // R10
            wd_cnt_r <= data_word; // R11
        end
        else if (tick && wd_act_r)
            wd_cnt_r <= wd_cnt_r - 16'h0001; // R24
    end

    // ------------------------------------------------------------
    // Reset sequencing and cause
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            boot_cnt_r <= STARTUP_POR; // R15
        else if (wd_fire)
            boot_cnt_r <= STARTUP_WDOG; // R16
        else if (lp_edge && boot_cnt_r != 4'h0)
            boot_cnt_r <= boot_cnt_r - 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cause_r <= CAUSE_POR; // R17
        else if (wd_fire)
            cause_r <= CAUSE_WDOG; // R17
        else if (sfr_wr && sfr_addr == ADDR_RESET_CAUSE)
            cause_r <= sfr_wdata[CAUSE_BIT];
    end

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
            power_mode_control_r <= MODE_RST; // R20
        else if (sfr_wr && sfr_addr == ADDR_POWER_MODE)
            power_mode_control_r <= sfr_wdata; // R18
        else if (irq_pending)
            power_mode_control_r[IDLE_BIT] <= 1'b0; // R19
    end

    // Only a clear of the power-down bit happens in hardware.
    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
            ck_r <= MODE_RST;
        else if (sfr_wr && sfr_addr == ADDR_CLK_SHUTDOWN)
            ck_r <= sfr_wdata; // R21
        else if (wake_ev || pin_wake)
            ck_r[PDOWN_BIT] <= 1'b0; // R9
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (sfr_rd)
        begin
            unique case (sfr_addr)
                ADDR_POWER_MODE:   rdata_r <= power_mode_control_r;
                ADDR_DATA_HIGH:    rdata_r <= data_hi_r;
                ADDR_DATA_LOW:     rdata_r <= data_lo_r;
                ADDR_SLOW_CMD:     rdata_r <= {3'b000, busy_r, cmd_r}; // R14
                ADDR_RESET_CAUSE:  rdata_r <= {7'b000_0000, cause_r};
                ADDR_TICK_DIV:     rdata_r <= div_r;
                ADDR_CLK_SHUTDOWN: rdata_r <= ck_r;
                default:           rdata_r <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_init)
            div_r <= TICK_DIV_RST;
        else if (sfr_wr && sfr_addr == ADDR_TICK_DIV)
            div_r <= sfr_wdata; // R1
    end

    assign sfr_rdata             = rdata_r;
    assign capture_trigger_input = cap_trig_r;
    assign wakeup_timer_irq      = wake_pulse_r;
    assign wake_irq_flag         = wake_flag_r;
    assign clock_regulator_run   = !ck_r[PDOWN_BIT]; // R21
    assign cpu_suspend           = power_mode_control_r[IDLE_BIT] || power_mode_control_r[STOP_BIT]
                                   || ck_r[PDOWN_BIT]; // R18
    assign cpu_reset             = (boot_cnt_r != 4'h0);
    assign boot_loader_sel       = (cause_r == CAUSE_POR); // R17

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_held: assert property (@(posedge clk_sys) disable iff (rst) // R24
        cmd_go && !wd_fire |=> busy_r && cmd_r == $past(sfr_wdata[3:0]))
        else $error("busy not raised by command");

    a_busy_clear: assert property (@(posedge clk_sys) disable iff (rst) // R14
        exec && !wd_fire |=> !busy_r)
        else $error("busy not cleared when taken");

    a_half_rate: assert property (@(posedge clk_sys) disable iff (rst) // R2
        lp_edge |=> capture_trigger_input != $past(capture_trigger_input))
        else $error("capture trigger missed a toggle");

    a_wake_load: assert property (@(posedge clk_sys) disable iff (rst) // R7
        exec_wake && !wd_fire |=> wake_en_r && wake_skip_r
        && wake_cnt_r == $past(data_word))
        else $error("wakeup load wrong");

    a_wake_reload: assert property (@(posedge clk_sys) disable iff (rst) // R3
        wake_ev && !wd_fire |=> wake_cnt_r == latch_r
        && wakeup_timer_irq && wake_irq_flag)
        else $error("wakeup event not reloaded or flagged");

    a_wdog_sticky: assert property (@(posedge clk_sys) disable iff (rst) // R10
        wd_act_r && !wd_fire |=> wd_act_r)
        else $error("watchdog dropped without reset");

    a_wdog_reset: assert property (@(posedge clk_sys) disable iff (rst) // R16
        wd_fire |=> cpu_reset && boot_cnt_r == STARTUP_WDOG
        && !boot_loader_sel && !wd_act_r)
        else $error("watchdog expiry did not reset");

    a_pdown_exit: assert property (@(posedge clk_sys) disable iff (rst) // R22
        ck_r[PDOWN_BIT] && (wake_ev || pin_wake)
        && !(sfr_wr && sfr_addr == ADDR_CLK_SHUTDOWN) |=> clock_regulator_run)
        else $error("power-down not ended by wake");

    a_idle_exit: assert property (@(posedge clk_sys) disable iff (rst) // R19
        power_mode_control_r[IDLE_BIT] && irq_pending && !wd_fire
        && !(sfr_wr && sfr_addr == ADDR_POWER_MODE) |=> !power_mode_control_r[IDLE_BIT])
        else $error("idle not ended by interrupt");

    a_stop_holds: assert property (@(posedge clk_sys) disable iff (rst) // R20
        power_mode_control_r[STOP_BIT] && !wd_fire
        && !(sfr_wr && sfr_addr == ADDR_POWER_MODE) |=> cpu_suspend)
        else $error("stop mode left without watchdog");

endmodule
`default_nettype wire

// ==== cpu_core_model.sv ====
/*
 * Model of the CPU core at the far side of the SFR bus: strobed byte
 * accesses, busy polling and the interrupt-pending level.
 * Assumes the block samples its strobes on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input  wire logic            clk_sys,
    input  wire lpwd_pkg::byte_t sfr_rdata,
    output var  lpwd_pkg::byte_t sfr_addr,
    output var  logic            sfr_wr,
    output var  logic            sfr_rd,
    output var  lpwd_pkg::byte_t sfr_wdata,
    output var  logic            irq_pending
);
    import lpwd_pkg::*;

    initial
    begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        irq_pending = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Released lines show the inverse of the last value, so a stale
    // address or data byte can never pass for a fresh one.
    task automatic wr(input byte_t a, input byte_t d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask

    task automatic rd(input byte_t a, output byte_t d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask

    task automatic wait_not_busy;
        byte_t v;
        v = 8'hFF;
        for (int i = 0; i < 100 && v[BUSY_BIT] !== 1'b0; i++)
            rd(ADDR_SLOW_CMD, v);
    endtask

    task automatic pulse_irq;
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        @(posedge clk_sys);
        irq_pending <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
 * Self-checking testbench for the wakeup timer, watchdog, reset-cause and
 * power-mode block. Assumes the CPU core model sits on the SFR bus.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lpwd_pkg::*;

    logic       clk_sys, rst, low_power_oscillator, wake_flag_clr, ext_irq_zero_n, ext_irq_one_n;
    logic [1:0] port0_alternate_select;
    byte_t      sfr_addr, sfr_wdata, sfr_rdata, rv;
    logic       sfr_wr, sfr_rd, irq_pending, capture_trigger_input, prev;
    logic       wakeup_timer_irq, wake_irq_flag, clock_regulator_run;
    logic       cpu_suspend, cpu_reset, boot_loader_sel;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         wake_cnt = 0;
    int         wake_at = 0;
    int         wake_gap = 0;
    int         n, k;

    lowpower_wakeup_watchdog dut (.clk_sys(clk_sys), .rst(rst), .low_power_oscillator(low_power_oscillator),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .irq_pending(irq_pending), .wake_flag_clr(wake_flag_clr),
        .ext_irq_zero_n(ext_irq_zero_n), .ext_irq_one_n(ext_irq_one_n),
        .port0_alternate_select(port0_alternate_select),
        .capture_trigger_input(capture_trigger_input), .wakeup_timer_irq(wakeup_timer_irq),
        .wake_irq_flag(wake_irq_flag), .clock_regulator_run(clock_regulator_run),
        .cpu_suspend(cpu_suspend), .cpu_reset(cpu_reset), .boot_loader_sel(boot_loader_sel));

    cpu_core_model cpu (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .irq_pending(irq_pending));

    // ------------------------------------------------------------
    // Clocks, timeout and wakeup pulse timing
    // ------------------------------------------------------------
    // The oscillator period is exactly 16 system cycles so tick gaps are exact.
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        low_power_oscillator = 1'b0;
        #3;
        forever #160 low_power_oscillator = ~low_power_oscillator;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (wakeup_timer_irq === 1'b1)
        begin
            wake_gap = cycles - wake_at;
            wake_at = cycles;
            wake_cnt++;
        end
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Compare and access tasks
    // ------------------------------------------------------------
    task automatic check8(input string what, input byte_t exp, input byte_t got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic rdchk(input string what, input byte_t a, input byte_t exp);
        cpu.rd(a, rv);
        check8(what, exp, rv);
    endtask

    // The write is placed just after an oscillator edge, so busy must still be set.
    task automatic cmd(input slow_op_t op);
        cpu.wait_not_busy();
        @(capture_trigger_input);
        cpu.wr(ADDR_SLOW_CMD, {4'h0, op});
        rdchk("busy", ADDR_SLOW_CMD, {4'h1, op});
        cpu.wait_not_busy();
    endtask

    task automatic load16(input logic [15:0] v, input slow_op_t op);
        cpu.wait_not_busy();
        cpu.wr(ADDR_DATA_HIGH, v[15:8]);
        cpu.wr(ADDR_DATA_LOW, v[7:0]);
        cmd(op);
    endtask

    task automatic wait_wakes(input int cnt);
        k = wake_cnt + cnt;
        for (n = 0; n < 1000 && wake_cnt < k; n++)
            @(posedge clk_sys);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic end_of_test;
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        wake_flag_clr = 1'b0;
        ext_irq_zero_n = 1'b1;
        ext_irq_one_n = 1'b1;
        port0_alternate_select = 2'b00;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        for (n = 0; n < 400 && cpu_reset !== 1'b0; n++)
            @(posedge clk_sys);
        check1("por_startup", 1'b1, n >= 208 && n <= 240);
        check1("boot_sel", 1'b1, boot_loader_sel);
        rdchk("cause", ADDR_RESET_CAUSE, 8'h00);
        rdchk("tick_div", ADDR_TICK_DIV, TICK_DIV_RST);
        rdchk("unmapped", 8'h80, 8'h00);
        check8("wakes_off", 8'h00, 8'(wake_cnt));
        $display("test reset done");

        cpu.wr(ADDR_TICK_DIV, 8'h00);
        prev = capture_trigger_input;
        n = 0;
        repeat (320)
        begin
            @(posedge clk_sys);
            if (capture_trigger_input !== prev)
                n++;
            prev = capture_trigger_input;
        end
        check8("capture_toggles", 8'd20, 8'(n));
        $display("test capture done");

        load16(16'h0002, OP_WAKE_LOAD);
        wait_wakes(2);
        check8("wake_gap_2", 8'd48, 8'(wake_gap));
        check1("wake_flag", 1'b1, wake_irq_flag);
        load16(16'h0004, OP_WAKE_LOAD);
        wait_wakes(2);
        check8("wake_gap_4", 8'd80, 8'(wake_gap));
        cpu.wait_not_busy();
        cpu.wr(ADDR_CLK_SHUTDOWN, 8'h03);
        settle();
        check1("pdown_timer", 1'b0, clock_regulator_run);
        wait_wakes(1);
        settle();
        check1("timer_wake", 1'b1, clock_regulator_run);
        cmd(OP_READ_LATCH);
        rdchk("latch_hi", ADDR_DATA_HIGH, 8'h00);
        rdchk("latch_lo", ADDR_DATA_LOW, 8'h04);
        cmd(OP_READ_COUNT);
        rdchk("count_hi", ADDR_DATA_HIGH, 8'h00);
        cpu.rd(ADDR_DATA_LOW, rv);
        check1("count_lo", 1'b1, rv <= 8'h04);
        cmd(OP_WAKE_OFF);
        k = wake_cnt;
        repeat (200) @(posedge clk_sys);
        check8("wake_off", 8'(k), 8'(wake_cnt));
        wake_flag_clr <= 1'b1;
        @(posedge clk_sys);
        wake_flag_clr <= 1'b0;
        settle();
        check1("flag_clear", 1'b0, wake_irq_flag);
        $display("test wakeup done");

        cpu.wr(ADDR_POWER_MODE, 8'h01);
        settle();
        check1("idle", 1'b1, cpu_suspend);
        cpu.pulse_irq();
        settle();
        check1("idle_exit", 1'b0, cpu_suspend);
        rdchk("idle_bit", ADDR_POWER_MODE, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            port0_alternate_select <= 2'b00;
            cpu.wait_not_busy();
            cpu.wr(ADDR_CLK_SHUTDOWN, 8'h02);
            settle();
            check1("pdown", 1'b0, clock_regulator_run);
            if (i == 0)
                ext_irq_zero_n <= 1'b0;
            else
                ext_irq_one_n <= 1'b0;
            repeat (20) @(posedge clk_sys);
            check1("pin_masked", 1'b0, clock_regulator_run);
            port0_alternate_select <= 2'(1 << i);
            repeat (10) @(posedge clk_sys);
            check1("pin_wake", 1'b1, clock_regulator_run);
            rdchk("pdown_bit", ADDR_CLK_SHUTDOWN, 8'h00);
            ext_irq_zero_n <= 1'b1;
            ext_irq_one_n <= 1'b1;
        end
        $display("test power done");

        load16(16'h0003, OP_WDOG_LOAD);
        cpu.wr(ADDR_POWER_MODE, 8'h02);
        settle();
        cpu.pulse_irq();
        settle();
        check1("stop_held", 1'b1, cpu_suspend);
        for (n = 0; n < 400 && cpu_reset !== 1'b1; n++)
            @(posedge clk_sys);
        check1("wdog_fired", 1'b1, cpu_reset);
        for (n = 0; n < 400 && cpu_reset !== 1'b0; n++)
            @(posedge clk_sys);
        check1("wdog_startup", 1'b1, n >= 176 && n <= 208);
        check1("boot_sel_wd", 1'b0, boot_loader_sel);
        check1("stop_exit", 1'b0, cpu_suspend);
        rdchk("cause_wd", ADDR_RESET_CAUSE, 8'h01);
        rdchk("tick_div_wd", ADDR_TICK_DIV, TICK_DIV_RST);
        $display("test watchdog done");
        end_of_test();
    end
endmodule
`default_nettype wire
